// *** rtl/mprc_defines.vh ***
// constants for the module power and reset sequencer
// assumes a 10 MHz clock; all times are converted to cycles here
`ifndef MPRC_DEFINES_VH
`define MPRC_DEFINES_VH

`define MPRC_CLK_MHZ 10
// carrier reset pulse length after a triggered reset, in microseconds
`define MPRC_RST_PULSE_US 10
`define MPRC_RST_PULSE_CYC (`MPRC_RST_PULSE_US * `MPRC_CLK_MHZ)
// suspend notice lead time before entering suspend, in microseconds
`define MPRC_SUS_LEAD_US 2
`define MPRC_SUS_LEAD_CYC (`MPRC_SUS_LEAD_US * `MPRC_CLK_MHZ)
`define MPRC_CNT_W 8

// power states
`define MPRC_ST_OFF 3'h0
`define MPRC_ST_ON 3'h1
`define MPRC_ST_PEND 3'h2
`define MPRC_ST_SLEEP 3'h3
`define MPRC_ST_WAKE 3'h4

`endif

// *** rtl/mprc_power_reset.v ***
// power state, carrier reset and system management pin logic
// assumes every pin input is asynchronous to clk; software and watchdog
// requests come from logic on clk as one-cycle pulses or levels
// carrier reset is a timed pulse; only power bad and off hold it as a level
`timescale 1ns/1ns
`include "mprc_defines.vh"

// Function
// - rising edge of power button with power good leaves soft-off and starts power-up
// - falling edge of reset button starts a system reset
// - reset releases after the timed pulse even if button stays low
// - drive active-low carrier reset output from module logic
// - carrier reset on button, supply bad, main supply low, watchdog, software
// - supply-good high means power good, low means not good
// - assert suspend-pending low before entering suspend
// - suspend-to-RAM indicator low for whole suspend state, else high
// - soft-off indicator low while in soft-off state
// - suspend-to-disk indicator never asserted, stays high
// - low PCI Express wake input wakes from low power
// - low auxiliary wake input wakes from low power
// - low battery-low input is a power management event
// - overtemperature input assertion is an overtemperature condition
// - thermal shutdown output low once processor is in thermal shutdown
// - low management alert raises management interrupt or wakes system
// - four general purpose outputs set by module logic
// - four general purpose inputs, unconnected reads one
// - watchdog output shows timeout; timeout also resets carrier
module mprc_power_reset (
    input wire clk, // 10 MHz standby clock
    input wire rstn, // async reset, active low
    input wire power_button_n, // power button pin
    input wire reset_button_n, // reset button pin
    input wire supply_good, // main supply good pin
    input wire main_supply_ok, // main supply above minimum
    input wire battery_low_n, // battery low pin
    input wire overtemp_in_n, // off-module overtemp pin
    input wire pcie_wake_n, // pcie wake pin
    input wire aux_wake_n, // general wake pin
    input wire mgmt_alert_n, // management bus alert pin
    input wire [3:0] gp_in, // general purpose input pins
    input wire cpu_thermal_trip, // processor thermal shutdown, clk domain
    input wire watchdog_timeout, // watchdog expiry pulse, clk domain
    input wire sw_reset_req, // software reset pulse, clk domain
    input wire sleep_req, // software suspend request pulse, clk domain
    input wire [3:0] gp_out_set, // requested general purpose outputs
    output reg carrier_reset_n, // carrier reset, active low
    output reg suspend_pending_n, // suspend imminent, active low
    output reg sleep_ram_n, // suspend to ram, active low
    output reg sleep_disk_n, // suspend to disk, always high
    output reg soft_off_n, // soft off, active low
    output reg cpu_thermal_shutdown_n, // thermal shutdown, active low
    output reg watchdog_expired, // watchdog timeout seen
    output reg mgmt_interrupt_n, // management interrupt, active low
    output reg battery_low_evt, // battery low event level
    output reg overtemp_evt, // overtemperature condition level
    output reg [3:0] gp_out, // general purpose outputs
    output reg [3:0] gp_in_val // synchronised general purpose inputs
);

    localparam SYNC_W = 12; // 8 single pins plus 4 gp inputs
    localparam [`MPRC_CNT_W-1:0] RST_CYC = `MPRC_RST_PULSE_CYC;
    localparam [`MPRC_CNT_W-1:0] LEAD_CYC = `MPRC_SUS_LEAD_CYC;

    // two-stage synchroniser for the pulled-up pins
    reg [SYNC_W-1:0] meta_ff; // first stage, read only by second stage
    reg [SYNC_W-1:0] sync_ff;

    // edge history and power state
    reg power_button_n_d_ff;
    reg rstbtn_d_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;

    // reset pulse and suspend lead timers
    reg [`MPRC_CNT_W-1:0] rst_cnt_ff;
    reg [`MPRC_CNT_W-1:0] nxt_rst_cnt;
    reg [`MPRC_CNT_W-1:0] lead_cnt_ff;
    reg [`MPRC_CNT_W-1:0] nxt_lead_cnt;

    // sticky watchdog memory
    reg wdt_ff;

    // synchronised views of the pins
    wire [SYNC_W-1:0] raw_in;
    wire s_power_button_n_n;
    wire s_rstbtn_n;
    wire s_supply_good;
    wire s_main_ok;
    wire s_battery_low_n_n;
    wire s_overtemp_in_n_n;
    wire s_pcie_wake_n_n;
    wire s_aux_wake_n_n;
    wire s_alert_n;
    wire [3:0] s_gp_in;

    // decoded events
    wire power_button_n_rise;
    wire rstbtn_fall;
    wire power_bad;
    wire wake_any;
    wire rst_trigger;

    // saturating one-step countdown, shared by both timers
    function [`MPRC_CNT_W-1:0] count_down;
        input [`MPRC_CNT_W-1:0] value;
        begin
            if (value == 8'h00)
                count_down = 8'h00;
            else
                count_down = value - 8'h01;
        end
    endfunction

    // one decode of a state code, used by the carrier reset, suspend-to-RAM and soft-off outputs
    function is_state;
        input [2:0] st;
        input [2:0] code;
        begin
            is_state = (st == code);
        end
    endfunction

    // suspend notice covers the lead time and the whole sleep
    function in_suspend;
        input [2:0] st;
        begin
            in_suspend = (st == `MPRC_ST_PEND) || (st == `MPRC_ST_SLEEP);
        end
    endfunction

    // every pin goes through two flops before use
    assign raw_in = {gp_in, mgmt_alert_n, aux_wake_n, pcie_wake_n, overtemp_in_n,
                     battery_low_n, main_supply_ok, supply_good, reset_button_n};

    // pins reset to their pulled-up idle level so no false edge at release
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= 12'hFFF;
            sync_ff <= 12'hFFF;
        end
        else
        begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    // power button kept apart: idle high, synchronised the same way
    // second stage is the only reader of the first
    reg pwr_meta_ff;
    reg pwr_sync_ff;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr_meta_ff <= 1'b1;
            pwr_sync_ff <= 1'b1;
        end
        else
        begin
            pwr_meta_ff <= power_button_n;
            pwr_sync_ff <= pwr_meta_ff;
        end
    end

    // sync_ff bit map: 0 reset button, 1 supply good, 2 main supply,
    // 3 battery low, 4 overtemp, 5 pcie wake, 6 aux wake, 7 alert,
    // 11..8 general purpose inputs
    assign s_power_button_n_n = pwr_sync_ff;
    assign s_rstbtn_n = sync_ff[0];
    assign s_supply_good = sync_ff[1];
    assign s_main_ok = sync_ff[2];
    assign s_battery_low_n_n = sync_ff[3];
    assign s_overtemp_in_n_n = sync_ff[4];
    assign s_pcie_wake_n_n = sync_ff[5];
    assign s_aux_wake_n_n = sync_ff[6];
    assign s_alert_n = sync_ff[7];
    assign s_gp_in = sync_ff[11:8];

    // edge detectors only look at the second stage
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_button_n_d_ff <= 1'b1;
            rstbtn_d_ff <= 1'b1;
        end
        else
        begin
            power_button_n_d_ff <= s_power_button_n_n;
            rstbtn_d_ff <= s_rstbtn_n;
        end
    end

    assign power_button_n_rise = s_power_button_n_n & ~power_button_n_d_ff;
    assign rstbtn_fall = ~s_rstbtn_n & rstbtn_d_ff;
    // supply-good low or main supply low count as power bad
    assign power_bad = ~s_supply_good | ~s_main_ok;
    // alert also wakes, as does either wake pin
    assign wake_any = ~s_pcie_wake_n_n | ~s_aux_wake_n_n | ~s_alert_n;
    // a held-low button is not a trigger; only its falling edge is
    assign rst_trigger = rstbtn_fall | watchdog_timeout | sw_reset_req;

    // power state machine
    // off -> on on a good-power button rise; on -> pending on a sleep request;
    // pending holds the notice for the lead time, then sleep; any wake
    // source or a button rise leaves sleep through one wake cycle.
    // limitation: there is no path from on back to off, since nothing
    // here asks for a shutdown; supply loss only holds the carrier reset
    always @*
    begin
        nxt_state = state_ff;
        nxt_lead_cnt = lead_cnt_ff;
        case (state_ff)
            // only a good-power button press leaves off
            `MPRC_ST_OFF:
            begin
                if (power_button_n_rise && !power_bad)
                    nxt_state = `MPRC_ST_ON;
            end
            // running; only software asks to sleep
            `MPRC_ST_ON:
            begin
                if (sleep_req)
                begin
                    nxt_state = `MPRC_ST_PEND;
                    nxt_lead_cnt = LEAD_CYC;
                end
            end
            `MPRC_ST_PEND:
            begin
                // notice stands for the lead time before sleep starts
                if (lead_cnt_ff <= 8'h01)
                    nxt_state = `MPRC_ST_SLEEP;
                else
                    nxt_lead_cnt = count_down(lead_cnt_ff);
            end
            // any wake source or button rise ends sleep
            `MPRC_ST_SLEEP:
            begin
                if (wake_any || power_button_n_rise)
                    nxt_state = `MPRC_ST_WAKE;
            end
            // one settling cycle before running
            `MPRC_ST_WAKE:
            begin
                nxt_state = `MPRC_ST_ON;
            end
            // unused codes fall back to off
            default:
            begin
                nxt_state = `MPRC_ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= `MPRC_ST_OFF;
            lead_cnt_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            lead_cnt_ff <= nxt_lead_cnt;
        end
    end

    // reset pulse counter: timed so a stuck button cannot hold reset
    // a new trigger restarts the full pulse
    always @*
    begin
        if (rst_trigger)
            nxt_rst_cnt = RST_CYC;
        else
            nxt_rst_cnt = count_down(rst_cnt_ff);
    end

    // preloaded so the carrier stays in reset after power-on
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_cnt_ff <= RST_CYC;
        else
            rst_cnt_ff <= nxt_rst_cnt;
    end

    // sticky watchdog flag, cleared only by a power button rise while off, even if power is bad
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wdt_ff <= 1'b0;
        else if (watchdog_timeout)
            wdt_ff <= 1'b1;
        else if (state_ff == `MPRC_ST_OFF && power_button_n_rise)
            wdt_ff <= 1'b0;
    end

    // registered outputs
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // every output resets to its idle or in-reset level
            carrier_reset_n <= 1'b0;
            suspend_pending_n <= 1'b1;
            sleep_ram_n <= 1'b1;
            sleep_disk_n <= 1'b1;
            soft_off_n <= 1'b0;
            cpu_thermal_shutdown_n <= 1'b1;
            watchdog_expired <= 1'b0;
            mgmt_interrupt_n <= 1'b1;
            battery_low_evt <= 1'b0;
            overtemp_evt <= 1'b0;
            gp_out <= 4'hF;
            gp_in_val <= 4'hF;
        end
        else
        begin
            // held in reset while off, power bad or pulse running
            carrier_reset_n <= ~(power_bad || (nxt_rst_cnt != 8'h00) ||
                                 is_state(nxt_state, `MPRC_ST_OFF));
            // suspend and off indicators follow the next state
            suspend_pending_n <= ~in_suspend(nxt_state);
            sleep_ram_n <= ~is_state(nxt_state, `MPRC_ST_SLEEP);
            sleep_disk_n <= 1'b1;
            soft_off_n <= ~is_state(nxt_state, `MPRC_ST_OFF);
            // pass-through levels, one flop deep
            cpu_thermal_shutdown_n <= ~cpu_thermal_trip;
            watchdog_expired <= wdt_ff | watchdog_timeout;
            mgmt_interrupt_n <= s_alert_n;
            battery_low_evt <= ~s_battery_low_n_n;
            overtemp_evt <= ~s_overtemp_in_n_n;
            gp_out <= gp_out_set;
            gp_in_val <= s_gp_in;
        end
    end

endmodule // mprc_power_reset

// *** sim/mprc_carrier.sv ***
// carrier board model: buttons, supply, sensors, wake sources
// pins idle high as pulled up; the bench moves them off the falling edge
`timescale 1ns/1ns
module mprc_carrier (
    input wire clk, // clock
    input wire sleep_ram_n, // ram indicator
    output wire supply_on, // rail enable
    output logic main_supply_ok, // main rail
    output logic supply_good, // supply good
    output logic power_button_n, // button
    output logic reset_button_n, // button
    output logic battery_low_n, // battery
    output logic overtemp_in_n, // sensor
    output logic pcie_wake_n, // wake
    output logic aux_wake_n, // wake
    output logic mgmt_alert_n, // alert
    output logic [3:0] gp_in // inputs
);
    // optional rail enable, inverted ram indicator
    assign supply_on = ~sleep_ram_n;
    // pulled-up idle levels, so a quiet pin reads one
    initial
    begin
        {main_supply_ok, supply_good, power_button_n, reset_button_n} = 4'hF;
        {battery_low_n, overtemp_in_n, pcie_wake_n, aux_wake_n, mgmt_alert_n} = 5'h1F;
        gp_in = 4'hF;
    end
    // good only reported while the main rail is up
    task set_supply(input logic main, input logic good);
        @(negedge clk);
        main_supply_ok = main;
        supply_good = good & main;
    endtask
endmodule // mprc_carrier

// *** sim/mprc_chk_asserts.sv ***
// port checker for the power and reset sequencer
// bound into mprc_power_reset; sees only its ports
`timescale 1ns/1ns
module mprc_chk (
    input wire clk, // clock
    input wire rstn, // reset
    input wire reset_button_n, // button
    input wire supply_good, // supply good
    input wire battery_low_n, // pin
    input wire overtemp_in_n, // pin
    input wire mgmt_alert_n, // pin
    input wire cpu_thermal_trip, // trip
    input wire watchdog_timeout, // expiry
    input wire [3:0] gp_out_set, // request
    input wire carrier_reset_n, // out
    input wire suspend_pending_n, // out
    input wire sleep_ram_n, // out
    input wire sleep_disk_n, // out
    input wire soft_off_n, // out
    input wire cpu_thermal_shutdown_n, // out
    input wire watchdog_expired, // out
    input wire mgmt_interrupt_n, // out
    input wire battery_low_evt, // out
    input wire overtemp_evt, // out
    input wire [3:0] gp_out // out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] held_ff;
    // counts cycles of reset held while the button stays low; a stuck button must not extend it
    always @(posedge clk or negedge rstn)
        if (!rstn)
            held_ff <= 8'h00;
        else if (carrier_reset_n || reset_button_n || !soft_off_n || !supply_good)
            held_ff <= 8'h00;
        else if (held_ff != 8'hFF)
            held_ff <= held_ff + 8'h01;
    a_hold_bound: assert property (held_ff < 8'd120) else $error("reset held by button");
    a_button_reset: assert property ($fell(reset_button_n) |-> ##[1:6] !carrier_reset_n)
        else $error("button did not reset");
    a_supply_reset: assert property ($fell(supply_good) |-> ##[2:6] !carrier_reset_n)
        else $error("supply loss did not reset");
    a_wdog_flag: assert property (watchdog_timeout |-> ##[1:2]
        (watchdog_expired && !carrier_reset_n)) else $error("watchdog not shown");
    a_off_reset: assert property (!soft_off_n |-> !carrier_reset_n) else $error("off not in reset");
    a_disk_idle: assert property (sleep_disk_n) else $error("disk indicator asserted");
    a_pend_first: assert property ($fell(sleep_ram_n) |->
        $past(suspend_pending_n, 10) == 1'b0) else $error("no suspend notice");
    a_thermal_out: assert property (1'b1 |=>
        cpu_thermal_shutdown_n == !$past(cpu_thermal_trip)) else $error("thermal out wrong");
    a_gpout_follow: assert property (1'b1 |=> gp_out == $past(gp_out_set)) else $error("gp out");
    a_batt_evt: assert property ($fell(battery_low_n) |-> ##[2:4] battery_low_evt)
        else $error("battery event");
    a_temp_evt: assert property ($fell(overtemp_in_n) |-> ##[2:4] overtemp_evt)
        else $error("overtemp event");
    a_alert_int: assert property ($fell(mgmt_alert_n) |-> ##[2:4] !mgmt_interrupt_n)
        else $error("alert interrupt");
    c_sleep: cover property ($fell(sleep_ram_n));
    c_wdog: cover property ($rose(watchdog_expired));
    c_held: cover property (held_ff == 8'd50);
endmodule // mprc_chk
bind mprc_power_reset mprc_chk chk (.*);

// *** sim/tb.sv ***
// self-checking bench for the power and reset sequencer
// carrier model owns the pins; bench drives the clk-domain requests
`timescale 1ns/1ns
module tb;
    logic clk = 0, rstn = 0, cpu_thermal_trip = 0, watchdog_timeout = 0, sw_reset_req = 0;
    logic sleep_req = 0;
    logic [3:0] gp_out_set = 4'hF;
    wire supply_on, main_supply_ok, supply_good, power_button_n, reset_button_n, battery_low_n;
    wire overtemp_in_n, pcie_wake_n, aux_wake_n, mgmt_alert_n, carrier_reset_n, suspend_pending_n;
    wire sleep_ram_n, sleep_disk_n, soft_off_n, cpu_thermal_shutdown_n, watchdog_expired;
    wire mgmt_interrupt_n, battery_low_evt, overtemp_evt;
    wire [3:0] gp_in, gp_out, gp_in_val;
    wire [3:0] evt_lvls = {battery_low_evt, overtemp_evt, mgmt_interrupt_n, cpu_thermal_shutdown_n};
    int num_errors = 0, tests_run = 0, cycles = 0;
    mprc_power_reset uut (.*);
    mprc_carrier carrier (.*);
    always #50 clk = ~clk;
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for the carrier reset to lift
    task wait_run;
        for (int i = 0; i < 300 && carrier_reset_n !== 1'b1; i++)
            cyc(1);
        check({3'h0, carrier_reset_n}, 4'h1);
    endtask
    task t_levels;
        cyc(1);
        check({1'b0, sleep_disk_n, carrier_reset_n, soft_off_n}, 4'h4);
        check(gp_in_val, 4'hF);
        {carrier.battery_low_n, carrier.overtemp_in_n, carrier.mgmt_alert_n} = 3'h0;
        carrier.gp_in = 4'hA;
        gp_out_set = 4'h5;
        cpu_thermal_trip = 1;
        cyc(5);
        check(gp_in_val, 4'hA);
        check(gp_out, 4'h5);
        check(evt_lvls, 4'hC);
        {carrier.battery_low_n, carrier.overtemp_in_n, carrier.mgmt_alert_n} = 3'h7;
        cpu_thermal_trip = 0;
        cyc(5);
        check(evt_lvls, 4'h3);
    endtask
    task t_power_on;
        // press refused while supply is bad
        carrier.set_supply(1'b1, 1'b0);
        carrier.power_button_n = 0;
        cyc(5);
        carrier.power_button_n = 1;
        cyc(6);
        check({3'h0, soft_off_n}, 4'h0);
        carrier.set_supply(1'b1, 1'b1);
        cyc(4);
        carrier.power_button_n = 0;
        cyc(5);
        carrier.power_button_n = 1;
        cyc(6);
        check({3'h0, soft_off_n}, 4'h1);
        wait_run;
    endtask
    task t_reset_button;
        carrier.reset_button_n = 0;
        cyc(8);
        check({3'h0, carrier_reset_n}, 4'h0);
        cyc(60);
        check({3'h0, carrier_reset_n}, 4'h0);
        wait_run;
        carrier.reset_button_n = 1;
    endtask
    // sleep, then wake from one source: 0 pcie, 1 aux, 2 alert, 3 button
    task t_suspend(input int src);
        sleep_req = 1;
        cyc(1);
        sleep_req = 0;
        cyc(3);
        check({2'h0, suspend_pending_n, sleep_ram_n}, 4'h1);
        cyc(25);
        check({2'h0, sleep_ram_n, supply_on}, 4'h1);
        {carrier.pcie_wake_n, carrier.aux_wake_n, carrier.mgmt_alert_n, carrier.power_button_n}
            = ~(4'h8 >> src);
        cyc(4);
        {carrier.pcie_wake_n, carrier.aux_wake_n, carrier.mgmt_alert_n, carrier.power_button_n}
            = 4'hF;
        cyc(8);
        check({2'h0, suspend_pending_n, sleep_ram_n}, 4'h3);
    endtask
    // reset causes: 0 supply bad, 1 main low, 2 watchdog, 3 software
    task t_cause(input int src);
        case (src)
            0: carrier.set_supply(1'b1, 1'b0);
            1: carrier.set_supply(1'b0, 1'b0);
            2: watchdog_timeout = 1;
            default: sw_reset_req = 1;
        endcase
        cyc(1);
        watchdog_timeout = 0;
        sw_reset_req = 0;
        cyc(6);
        check({2'h0, carrier_reset_n, watchdog_expired}, {3'h0, src >= 2});
        carrier.set_supply(1'b1, 1'b1);
        wait_run;
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        rstn = 1;
        t_levels;
        t_power_on;
        t_reset_button;
        for (int i = 0; i < 4; i++)
            t_suspend(i);
        for (int i = 0; i < 4; i++)
            t_cause(i);
        print_verdict;
    end
endmodule // tb
